/* lgpc_global_pin_control.sv */
// Global pin control: shared address/config pins, output enable, clock edge
// ------------------------------------------------------------
// ------------------------------------------------------------
`timescale 1ns/10ps
module lgpc_global_pin_control #(
    parameter int NUM_CH = lgpc_pkg::NUM_CHANNELS
) (
    // Clock and reset
    input  wire logic                 mclk,
    input  wire logic                 resetn,
    // Device mode, from the mode pins decode
    input  wire lgpc_pkg::lgpc_mode_t hostMode,
    // Shared address/configuration pins
    input  wire logic [4:0]           addrCfgPins,
    // Global pins
    input  wire logic                 outputEnable,
    input  wire logic                 clock_edge_select,
    // Register bits from the register bank
    input  wire logic                 oe_rx_termination_ctrl,
    input  wire logic [NUM_CH-1:0]    rx_clock_invert_reg,
    // Serial port phase from the serial host engine
    input  wire lgpc_pkg::lgpc_sp_t   serialPhase,
    input  wire logic                 serialDataBit,
    input  wire logic                 serialClkRise,
    input  wire logic                 serialClkFall,
    // Decoded outputs
    output logic [4:0]                regAddr,
    output logic                      addrValid,
    output logic                      rx_term_mode_select,
    output logic [3:0]                monitor_source_select,
    output logic                      monEnable,
    output logic                      monIsTx,
    output logic [2:0]                monChannel,
    output logic [NUM_CH-1:0]         txLineHighZ,
    output logic [NUM_CH-1:0]         rxTermOff,
    output logic [NUM_CH-1:0]         rxClockInvert,
    // Serial output pin
    output logic                      serial_host_out,
    output logic                      serialOutEn
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [6:0] pinsSync;
    logic [4:0] cfgSync;
    logic       oeSync;
    logic       edgeSync;

    // Strap levels may change at any time; two flops cost two cycles of latency
    lgpc_sync #(
        .WIDTH (7)
    ) u_sync (
        .mclk    (mclk),
        .resetn  (resetn),
        .pinIn   ({clock_edge_select, outputEnable, addrCfgPins}),
        .pinSync (pinsSync)
    );

    assign cfgSync  = pinsSync[4:0];
    assign oeSync   = pinsSync[5];
    assign edgeSync = pinsSync[6];

    // ------------------------------------------------------------
    // Mode-dependent decode of the shared pins
    // ------------------------------------------------------------
    logic hwMode;
    logic parMode;
    assign hwMode  = (hostMode == lgpc_pkg::LGPC_HW);
    assign parMode = (hostMode == lgpc_pkg::LGPC_PARALLEL);

    // Address only in parallel host mode; serial and muxed hosts ground the pins anyway
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            regAddr   <= lgpc_pkg::ADDR_RESET;
            addrValid <= 1'b0;
        end else begin
            regAddr   <= parMode ? cfgSync : lgpc_pkg::ADDR_RESET;
            addrValid <= parMode;
        end
    end

    // Hardware mode configuration; held at defaults in host modes
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rx_term_mode_select   <= 1'b0;
            monitor_source_select <= lgpc_pkg::MON_RESET;
        end else if (hwMode) begin
            rx_term_mode_select   <= cfgSync[4];
            monitor_source_select <= cfgSync[3:0];
        end else begin
            rx_term_mode_select   <= 1'b0;
            monitor_source_select <= lgpc_pkg::MON_RESET;
        end
    end

    // Monitor routing: channel field 1..7 maps to channels 2..8, zero is off
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            monEnable  <= 1'b0;
            monIsTx    <= 1'b0;
            monChannel <= 3'h0;
        end else begin
            monEnable  <= hwMode && (cfgSync[2:0] != 3'h0);
            monIsTx    <= hwMode && cfgSync[lgpc_pkg::MON_TX_BIT];
            monChannel <= hwMode ? cfgSync[2:0] : 3'h0;
        end
    end

    // ------------------------------------------------------------
    // Global enable and clock edge, applied to all channels at once
    // ------------------------------------------------------------
    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch++) begin : g_chan
            always_ff @(posedge mclk or negedge resetn) begin
                if (!resetn) begin
                    txLineHighZ[ch]   <= 1'b1;  // Quiet line until enable is seen
                    rxTermOff[ch]     <= 1'b0;
                    rxClockInvert[ch] <= 1'b0;
                end else begin
                    txLineHighZ[ch]   <= !oeSync;
                    rxTermOff[ch]     <= !oeSync && oe_rx_termination_ctrl;
                    rxClockInvert[ch] <= edgeSync | rx_clock_invert_reg[ch];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Serial output driver
    // ------------------------------------------------------------
    // Launching on the opposite serial edge leaves the bit settled at the sampling edge
    logic launch;
    // Edge choice follows clock edge pin; the other edge is the sample edge
    assign launch = edgeSync ? serialClkRise : serialClkFall;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            serial_host_out <= 1'b0;
            serialOutEn     <= 1'b0;
        end else begin
            serialOutEn <= (serialPhase == lgpc_pkg::LGPC_SP_READ);
            if (launch && serialPhase == lgpc_pkg::LGPC_SP_READ) begin
                serial_host_out <= serialDataBit;
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence oeLowSeen;
        !oeSync;
    endsequence

    // A read bit leaves only on the launch edge chosen by the clock edge pin
    sequence readLaunch;
        launch && serialPhase == lgpc_pkg::LGPC_SP_READ;
    endsequence

    // Hardware mode with a non-zero channel field asks for monitoring
    sequence monRequested;
        hwMode && cfgSync[2:0] != 3'h0;
    endsequence

    AST_TX_HIGHZ: assert property (@(posedge mclk) disable iff (!resetn)
        oeLowSeen |=> txLineHighZ == '1) else $error("Transmitters not high impedance with enable low");
    AST_RX_TERM: assert property (@(posedge mclk) disable iff (!resetn)
        (!oeSync && oe_rx_termination_ctrl) |=> rxTermOff == '1) else $error("Receive termination not off");
    AST_RX_TERM_KEEP: assert property (@(posedge mclk) disable iff (!resetn)
        !oe_rx_termination_ctrl |=> rxTermOff == '0) else $error("Termination dropped without control bit");
    AST_CLK_INV: assert property (@(posedge mclk) disable iff (!resetn)
        edgeSync |=> rxClockInvert == '1) else $error("Receive clocks not inverted");
    AST_CLK_REG: assert property (@(posedge mclk) disable iff (!resetn)
        !edgeSync |=> rxClockInvert == $past(rx_clock_invert_reg)) else $error("Inversion ignores register");
    AST_ADDR: assert property (@(posedge mclk) disable iff (!resetn)
        parMode |=> regAddr == $past(cfgSync) && addrValid) else $error("Address not taken from pins");
    AST_HW_CFG: assert property (@(posedge mclk) disable iff (!resetn)
        hwMode |=> monitor_source_select == $past(cfgSync[3:0])) else $error("Monitor select wrong");
    AST_TERM_SEL: assert property (@(posedge mclk) disable iff (!resetn)
        hwMode |=> rx_term_mode_select == $past(cfgSync[4])) else $error("Termination select wrong");
    AST_IGNORE: assert property (@(posedge mclk) disable iff (!resetn)
        !hwMode |=> !monEnable && !rx_term_mode_select) else $error("Hardware function used in host mode");
    AST_SDO_Z: assert property (@(posedge mclk) disable iff (!resetn)
        serialPhase != lgpc_pkg::LGPC_SP_READ |=> !serialOutEn) else $error("Serial output driven off read");

    // Line side: enable high must release every transmitter
    AST_TX_DRIVE: assert property (@(posedge mclk) disable iff (!resetn)
        oeSync |=> txLineHighZ == '0) else $error("Transmitters held high impedance with enable high");
    // Decode: address is zero and invalid outside parallel host mode
    AST_ADDR_OFF: assert property (@(posedge mclk) disable iff (!resetn)
        !parMode |=> regAddr == lgpc_pkg::ADDR_RESET && !addrValid)
        else $error("Address decoded outside parallel mode");
    // Monitor routing follows the channel and direction fields
    AST_MON_ON: assert property (@(posedge mclk) disable iff (!resetn)
        monRequested |=> monEnable) else $error("Monitoring not enabled");
    AST_MON_OFF: assert property (@(posedge mclk) disable iff (!resetn)
        (hwMode && cfgSync[2:0] == 3'h0) |=> !monEnable) else $error("Monitoring enabled with channel field zero");
    AST_MON_CH: assert property (@(posedge mclk) disable iff (!resetn)
        hwMode |=> monChannel == $past(cfgSync[2:0]) && monIsTx == $past(cfgSync[lgpc_pkg::MON_TX_BIT]))
        else $error("Monitor channel or direction wrong");
    // Serial port: driven in reads, bit changes only on the launch edge
    AST_SDO_EN: assert property (@(posedge mclk) disable iff (!resetn)
        serialPhase == lgpc_pkg::LGPC_SP_READ |=> serialOutEn) else $error("Serial output not driven in read");
    AST_SDO_LAUNCH: assert property (@(posedge mclk) disable iff (!resetn)
        readLaunch |=> serial_host_out == $past(serialDataBit)) else $error("Read bit not launched");
    AST_SDO_HOLD: assert property (@(posedge mclk) disable iff (!resetn)
        !(launch && serialPhase == lgpc_pkg::LGPC_SP_READ) |=> $stable(serial_host_out))
        else $error("Serial output changed off the launch edge");
endmodule : lgpc_global_pin_control

/* lgpc_pkg.sv */
// Package of constants for the global pin control block
package lgpc_pkg;
    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int NUM_CHANNELS = 8;
    localparam int ADDR_WIDTH   = 5;
    localparam int MON_WIDTH    = 4;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [4:0] ADDR_RESET    = 5'h00;
    localparam logic [3:0] MON_RESET     = 4'h0;
    localparam logic [7:0] CHAN_RESET    = 8'h00;

    // Monitor select fields: bit 3 picks transmitter, bits 2:0 pick channel
    localparam int MON_TX_BIT = 3;

    // Host and hardware operating modes
    typedef enum logic [1:0] {
        LGPC_HW       = 2'b00,
        LGPC_PARALLEL = 2'b01,
        LGPC_MUXED    = 2'b11,
        LGPC_SERIAL   = 2'b10
    } lgpc_mode_t;

    // Serial port phases
    typedef enum logic [1:0] {
        LGPC_SP_IDLE = 2'b00,
        LGPC_SP_CMD  = 2'b01,
        LGPC_SP_READ = 2'b11,
        LGPC_SP_WRIT = 2'b10
    } lgpc_sp_t;
endpackage : lgpc_pkg

/* lgpc_sync.sv */
// Two-flop synchroniser for a bundle of pin levels
`timescale 1ns/10ps
module lgpc_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             resetn,
    // Levels
    input  wire logic [WIDTH-1:0] pinIn,
    output logic      [WIDTH-1:0] pinSync
);
    logic [WIDTH-1:0] meta_q;

    // First stage only feeds the second stage
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            meta_q  <= '0;
            pinSync <= '0;
        end else begin
            meta_q  <= pinIn;
            pinSync <= meta_q;
        end
    end
endmodule : lgpc_sync

/* lgpc_strap_model.sv */
// Board strapping model driving the shared address/configuration pins
`timescale 1ns/10ps
module lgpc_strap_model (
    // Mode and wanted level
    input  wire lgpc_pkg::lgpc_mode_t hostMode,
    input  wire logic [4:0]           wantPins,
    // Shared pins
    output logic      [4:0]           addrCfgPins
);
    // Serial and muxed hosts never use these pins, so the board grounds them
    always_comb begin
        if (hostMode == lgpc_pkg::LGPC_SERIAL || hostMode == lgpc_pkg::LGPC_MUXED) begin
            addrCfgPins = 5'h00;
        end else begin
            addrCfgPins = wantPins;
        end
    end
endmodule : lgpc_strap_model

/* lgpc_global_pin_control_tb.sv */
// Self-checking bench for the global pin control block
`timescale 1ns/10ps
module lgpc_global_pin_control_tb;
    // ------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------
    logic                 mclk, resetn, oe, cse, termCtrl, dBit, sRise, sFall, addrValid, rxTerm;
    logic                 monEn, monTx, sOut, sOutEn;
    logic [4:0]           want, pins, regAddr;
    logic [3:0]           monSel;
    logic [2:0]           monCh;
    logic [7:0]           invReg, txHz, termOff, clkInv;
    lgpc_pkg::lgpc_mode_t mode;
    lgpc_pkg::lgpc_sp_t   phase;
    int                   n_fail, samples_checked;

    lgpc_strap_model u_lgpc_strap_model (.hostMode(mode), .wantPins(want), .addrCfgPins(pins));
    lgpc_global_pin_control u_lgpc_global_pin_control (.mclk(mclk), .resetn(resetn), .hostMode(mode),
        .addrCfgPins(pins), .outputEnable(oe), .clock_edge_select(cse), .oe_rx_termination_ctrl(termCtrl),
        .rx_clock_invert_reg(invReg), .serialPhase(phase), .serialDataBit(dBit), .serialClkRise(sRise),
        .serialClkFall(sFall), .regAddr(regAddr), .addrValid(addrValid), .rx_term_mode_select(rxTerm),
        .monitor_source_select(monSel), .monEnable(monEn), .monIsTx(monTx), .monChannel(monCh),
        .txLineHighZ(txHz), .rxTermOff(termOff), .rxClockInvert(clkInv), .serial_host_out(sOut),
        .serialOutEn(sOutEn));

    // Free-running 50 MHz clock
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    // Compare, count and report at once
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Pins need three edges to land, so four edges plus a settle
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : step

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : wrap_up

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_modes();
        @(posedge mclk); mode <= lgpc_pkg::LGPC_PARALLEL; want <= 5'h15;
        step(4);
        chk("regAddr", 8'h15, 8'(regAddr));
        chk("addrValid", 8'h01, 8'(addrValid));
        chk("monSel off", 8'h00, 8'(monSel));
        chk("par hw off", 8'h00, 8'({rxTerm, monEn, monTx}));
        @(posedge mclk); mode <= lgpc_pkg::LGPC_MUXED; want <= 5'h1F;
        step(4);
        chk("muxed addr", 8'h00, 8'({addrValid, regAddr}));
        chk("muxed hw off", 8'h00, 8'({rxTerm, monEn, monSel}));
        @(posedge mclk); mode <= lgpc_pkg::LGPC_HW; want <= 5'h1A;
        step(4);
        chk("termSel hi", 8'h01, 8'(rxTerm));
        chk("monSel", 8'h0A, 8'(monSel));
        chk("mon tx ch3", 8'h1A, 8'({monEn, monTx, monCh}));
        chk("regAddr hw", 8'h00, 8'(regAddr));
        @(posedge mclk); want <= 5'h07;
        step(4);
        chk("termSel lo", 8'h00, 8'(rxTerm));
        chk("mon rx ch8", 8'h17, 8'({monEn, monTx, monCh}));
        @(posedge mclk); mode <= lgpc_pkg::LGPC_SERIAL; want <= 5'h1F;
        step(4);
        chk("serial addr", 8'h00, 8'({addrValid, regAddr}));
        chk("serial mon", 8'h00, 8'({rxTerm, monSel}));
    endtask : t_modes

    task automatic t_global();
        @(posedge mclk); termCtrl <= 1'b1; oe <= 1'b0; invReg <= 8'h5A; cse <= 1'b1;
        step(4);
        chk("txHighZ", 8'hFF, txHz);
        chk("termOff", 8'hFF, termOff);
        chk("clkInv forced", 8'hFF, clkInv);
        @(posedge mclk); termCtrl <= 1'b0; cse <= 1'b0;
        step(4);
        chk("termOff kept", 8'h00, termOff);
        chk("clkInv reg", 8'h5A, clkInv);
        @(posedge mclk); oe <= 1'b1; termCtrl <= 1'b1;
        step(4);
        chk("txDriven", 8'h00, txHz);
        chk("termOff oe hi", 8'h00, termOff);
    endtask : t_global

    task automatic t_serial();
        @(posedge mclk); phase <= lgpc_pkg::LGPC_SP_WRIT;
        step(2);
        chk("outEn write", 8'h00, 8'(sOutEn));
        @(posedge mclk); phase <= lgpc_pkg::LGPC_SP_CMD;
        step(2);
        chk("outEn cmd", 8'h00, 8'(sOutEn));
        // Clock edge low: bit launched on the falling serial edge, valid on the rising one
        @(posedge mclk); phase <= lgpc_pkg::LGPC_SP_READ; dBit <= 1'b1; sFall <= 1'b1;
        @(posedge mclk); sFall <= 1'b0;
        step(2);
        chk("outEn read", 8'h01, 8'(sOutEn));
        chk("fall launch", 8'h01, 8'(sOut));
        @(posedge mclk); dBit <= 1'b0; sRise <= 1'b1;
        @(posedge mclk); sRise <= 1'b0;
        step(2);
        chk("rise ignored", 8'h01, 8'(sOut));
        // Clock edge high: launch moves to the rising serial edge
        @(posedge mclk); cse <= 1'b1;
        step(4);
        @(posedge mclk); sRise <= 1'b1;
        @(posedge mclk); sRise <= 1'b0; dBit <= 1'b1;
        step(2);
        chk("rise launch", 8'h00, 8'(sOut));
        @(posedge mclk); sFall <= 1'b1;
        @(posedge mclk); sFall <= 1'b0;
        step(2);
        chk("fall ignored", 8'h00, 8'(sOut));
        @(posedge mclk); phase <= lgpc_pkg::LGPC_SP_WRIT;
        step(2);
        chk("outEn after read", 8'h00, 8'(sOutEn));
    endtask : t_serial

    // Main sequence with reset held through six rising clock edges
    initial begin
        {resetn, cse, termCtrl, dBit, sRise, sFall} = '0;
        oe = 1'b1;
        want = 5'h00;
        invReg = 8'h00;
        mode = lgpc_pkg::LGPC_HW;
        phase = lgpc_pkg::LGPC_SP_IDLE;
        step(5);
        chk("txHighZ reset", 8'hFF, txHz);
        @(posedge mclk); resetn <= 1'b1;
        step(2);
        t_modes();
        t_global();
        t_serial();
        wrap_up();
    end

    // Watchdog well beyond the roughly eighty cycles the scenarios need
    initial begin
        repeat (3000) @(posedge mclk);
        n_fail++;
        wrap_up();
    end
endmodule : lgpc_global_pin_control_tb
